// ===== inc/lpddr_rd_pkg.sv
// constants, types and small decoders shared by the read path, its command model and its bench
// assumes one command clock; the controller drives pins synchronous to clk
package lpddr_rd_pkg;

  // pin and address geometry
  localparam int BA_W   = 2;
  localparam int NBANK  = 4;
  localparam int ADDR_W = 13;
  localparam int COL_W  = 10;
  localparam int CP_W   = COL_W - 1;  // column pair index (2n prefetch)
  localparam int DQ_W   = 16;
  localparam int AP_BIT = 10;         // auto precharge / all-banks select

  // timing: minimum active time before an internal precharge
  localparam int CLK_NS    = 25;
  localparam int T_RAS_NS  = 42;
  localparam int RAS_RAW   = (T_RAS_NS + CLK_NS - 1) / CLK_NS;
  localparam int RAS_CYC   = (RAS_RAW < 1) ? 1 : RAS_RAW;
  localparam int RAS_CNT_W = $clog2(RAS_CYC + 1);

  // command codes as {ras_n, cas_n, we_n} with cs_n low
  localparam logic [2:0] CODE_ACT = 3'h3;
  localparam logic [2:0] CODE_RD  = 3'h5;
  localparam logic [2:0] CODE_PRE = 3'h2;
  localparam logic [2:0] CODE_BST = 3'h6;
  localparam logic [2:0] CODE_NOP = 3'h7;

  // burst length select and the pair counts they give
  localparam logic [1:0] BL_SEL_4 = 2'h2;
  localparam logic [1:0] BL_SEL_8 = 2'h3;
  localparam logic [2:0] PAIRS_2  = 3'h1;
  localparam logic [2:0] PAIRS_4  = 3'h2;
  localparam logic [2:0] PAIRS_8  = 3'h4;

  typedef enum logic [2:0] {CMD_NOP, CMD_ACT, CMD_RD, CMD_PRE, CMD_BST, CMD_OTHER} cmd_t;
  typedef enum logic {ST_IDLE = 1'b0, ST_BURST = 1'b1} state_t;

  // command decode from the four control pins
  function automatic cmd_t cmd_of(logic cs_n, logic ras_n, logic cas_n, logic we_n);
    cmd_t c;
    c = CMD_OTHER;
    if (cs_n)
      c = CMD_NOP;
    else
      case ({ras_n, cas_n, we_n})
        CODE_ACT: c = CMD_ACT;
        CODE_RD:  c = CMD_RD;
        CODE_PRE: c = CMD_PRE;
        CODE_BST: c = CMD_BST;
        CODE_NOP: c = CMD_NOP;
        default:  c = CMD_OTHER;
      endcase
    return c;
  endfunction : cmd_of

  // data pairs per burst; unused select code falls back to two elements
  function automatic logic [2:0] pairs_of(logic [1:0] sel);
    logic [2:0] p;
    p = PAIRS_2;
    if (sel == BL_SEL_8)
      p = PAIRS_8;
    else if (sel == BL_SEL_4)
      p = PAIRS_4;
    return p;
  endfunction : pairs_of

  // next column pair, wrapping inside the burst-aligned block
  function automatic logic [CP_W-1:0] cp_next(logic [CP_W-1:0] cp, logic [2:0] pairs);
    logic [CP_W-1:0] mask;
    logic [CP_W-1:0] inc;
    mask = CP_W'(pairs - 3'h1);
    inc  = CP_W'(cp + 1'b1);
    return (cp & ~mask) | (inc & mask);
  endfunction : cp_next

endpackage : lpddr_rd_pkg

// ===== inc/mem_if.sv
// carrier between the read path and its storage array
// assumes both ends run on the same clock
`timescale 1ns/100ps
`default_nettype none
interface mem_if #(parameter int AW = 8, parameter int DW = 32);
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  modport ctrl (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
  modport mem  (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface : mem_if
`default_nettype wire

// ===== src/pair_mem.sv
// storage array holding one data pair per word, registered read
// assumes the writer loads it before reads are expected to return content
`timescale 1ns/100ps
`default_nettype none
module pair_mem #(
  parameter int AW = 8,
  parameter int DW = 32
) (
  input wire logic clk,   // command clock
  mem_if.mem       port   // read and load port
);
  logic [DW-1:0] store [0:(1<<AW)-1];

  // load path, then read data out of a register every cycle
  always_ff @(posedge clk)
  begin
    if (port.wr_en)
      store[port.wr_addr] <= port.wr_data;
    port.rd_data <= store[port.rd_addr];
  end
endmodule : pair_mem
`default_nettype wire

// ===== src/lpddr_read_path.sv
// device side of a low power DDR read path: row activation, read bursts,
// truncation, auto precharge, and pairwise data/strobe output with tristates
// assumes command pins are synchronous to clk; each clk cycle carries one pair
`timescale 1ns/100ps
`default_nettype none
module lpddr_read_path #(
  parameter int MEM_ROW_BITS = 2,  // row bits backed by storage
  parameter int MEM_CP_BITS  = 4   // column pair bits backed by storage
) (
  input  wire logic                              clk,       // command clock
  input  wire logic                              nrst,      // async reset, low
  input  wire logic                              cs_n,      // chip select, low
  input  wire logic                              ras_n,     // row strobe, low
  input  wire logic                              cas_n,     // column strobe, low
  input  wire logic                              we_n,      // write enable, low
  input  wire logic [lpddr_rd_pkg::BA_W-1:0]     ba,        // bank address
  input  wire logic [lpddr_rd_pkg::ADDR_W-1:0]   addr,      // row / column address
  input  wire logic                              cl3,       // 1: latency 3, 0: latency 2
  input  wire logic [1:0]                        bl_sel,    // burst length select
  input  wire logic                              load_en,   // storage load strobe
  input  wire logic [lpddr_rd_pkg::BA_W+MEM_ROW_BITS+MEM_CP_BITS-1:0] load_addr, // load word
  input  wire logic [2*lpddr_rd_pkg::DQ_W-1:0]   load_data, // {rise, fall} pair
  output logic      [lpddr_rd_pkg::DQ_W-1:0]     dq_rise,   // element on rising edge
  output logic      [lpddr_rd_pkg::DQ_W-1:0]     dq_fall,   // element on falling edge
  output logic                                   dq_oe_n,   // data drive, low
  output logic                                   dqs_o,     // strobe, first half
  output logic                                   dqs_oe_n,  // strobe drive, low
  output logic      [lpddr_rd_pkg::NBANK-1:0]    bank_open  // open row per bank
);
  localparam int AW   = lpddr_rd_pkg::BA_W + MEM_ROW_BITS + MEM_CP_BITS;
  localparam int DW   = 2 * lpddr_rd_pkg::DQ_W;
  localparam int NB   = lpddr_rd_pkg::NBANK;
  localparam int CP_W = lpddr_rd_pkg::CP_W;
  localparam int RCW  = lpddr_rd_pkg::RAS_CNT_W;
  localparam logic [RCW-1:0] RAS_MET = RCW'(lpddr_rd_pkg::RAS_CYC);
  localparam logic [2:0] PAIRS_ONE = lpddr_rd_pkg::PAIRS_2;  // one pair left in the burst

  lpddr_rd_pkg::cmd_t   cmd;
  lpddr_rd_pkg::state_t state;
  lpddr_rd_pkg::state_t next_state;
  logic [lpddr_rd_pkg::ADDR_W-1:0] bank_row [0:NB-1];
  logic [RCW-1:0]       ras_cnt [0:NB-1];
  logic [NB-1:0]        ap_pend;
  logic [NB-1:0]        ap_fire;
  logic [NB-1:0]        ras_met;
  logic [lpddr_rd_pkg::BA_W-1:0] burst_bank;
  logic [CP_W-1:0]      burst_cp;
  logic [2:0]           pairs_left;
  logic                 burst_ap;
  logic [lpddr_rd_pkg::BA_W-1:0] next_bank;
  logic [CP_W-1:0]      next_cp;
  logic [2:0]           next_left;
  logic                 next_ap;
  logic                 s0_v;
  logic                 s1_v;
  logic [DW-1:0]        s1_d;
  logic                 out_pre;
  logic [2:0]           burst_pairs;  // block size of the running burst

  wire        is_act   = (cmd == lpddr_rd_pkg::CMD_ACT);
  wire        is_rd    = (cmd == lpddr_rd_pkg::CMD_RD);
  wire        is_pre   = (cmd == lpddr_rd_pkg::CMD_PRE);
  wire        is_bst   = (cmd == lpddr_rd_pkg::CMD_BST);
  wire        sel_all  = addr[lpddr_rd_pkg::AP_BIT];
  wire [2:0]  bl_pairs = lpddr_rd_pkg::pairs_of(bl_sel);
  wire [CP_W-1:0] cmd_cp = addr[lpddr_rd_pkg::COL_W-1:1];

  // command decode and qualification
  assign cmd = lpddr_rd_pkg::cmd_of(cs_n, ras_n, cas_n, we_n);
  // reads to a closed bank are dropped; the controller must not issue them
  wire rd_ok = is_rd & bank_open[ba];
  wire bursting = (state == lpddr_rd_pkg::ST_BURST);
  // precharge cuts the running burst only when it targets that bank
  wire pre_cut = is_pre & bursting & ~burst_ap & (sel_all | (ba == burst_bank));
  // a new READ supersedes the running burst: concatenation or truncation
  wire cont    = bursting & ~is_bst & ~pre_cut & ~rd_ok;

  // element pair issued to storage this cycle
  wire                 issue_v  = rd_ok | cont;
  wire [lpddr_rd_pkg::BA_W-1:0] iss_bank = rd_ok ? ba : burst_bank;
  wire [CP_W-1:0]      iss_cp   = rd_ok ? cmd_cp : burst_cp; // starting column first
  wire [2:0]           iss_left = rd_ok ? bl_pairs : pairs_left;
  wire                 iss_last = issue_v & (iss_left == PAIRS_ONE);
  wire                 iss_ap   = rd_ok ? sel_all : burst_ap;
  wire [lpddr_rd_pkg::ADDR_W-1:0] iss_row = bank_row[iss_bank];

  mem_if #(.AW(AW), .DW(DW)) mbus ();

  // storage address: bank, low row bits, low column pair bits
  assign mbus.rd_addr = {iss_bank, iss_row[MEM_ROW_BITS-1:0], iss_cp[MEM_CP_BITS-1:0]};
  assign mbus.wr_en   = load_en;
  assign mbus.wr_addr = load_addr;
  assign mbus.wr_data = load_data;

  pair_mem #(.AW(AW), .DW(DW)) u_store (
    .clk  (clk),
    .port (mbus)
  );

  // burst engine next state; pairs wrap within the burst block
  always_comb
  begin
    next_state = state;
    next_bank  = burst_bank;
    next_cp    = burst_cp;
    next_left  = pairs_left;
    next_ap    = burst_ap;
    case (state)
      lpddr_rd_pkg::ST_IDLE,
      lpddr_rd_pkg::ST_BURST:
      begin
        if (issue_v)
        begin
          next_bank  = iss_bank;
          next_cp    = lpddr_rd_pkg::cp_next(iss_cp, rd_ok ? bl_pairs : burst_pairs);
          next_left  = iss_left - 3'h1;
          next_ap    = iss_ap;
          next_state = iss_last ? lpddr_rd_pkg::ST_IDLE : lpddr_rd_pkg::ST_BURST;
        end
        else
          next_state = lpddr_rd_pkg::ST_IDLE; // terminated, precharged or idle
      end
      default: next_state = lpddr_rd_pkg::ST_IDLE;
    endcase
  end

  // burst engine registers; the block size is kept for the wrap
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state       <= lpddr_rd_pkg::ST_IDLE;
      burst_bank  <= '0;
      burst_cp    <= '0;
      pairs_left  <= 3'h0;
      burst_ap    <= 1'b0;
      burst_pairs <= lpddr_rd_pkg::PAIRS_2;
    end
    else
    begin
      state      <= next_state;
      burst_bank <= next_bank;
      burst_cp   <= next_cp;
      pairs_left <= next_left;
      burst_ap   <= next_ap;
      if (rd_ok)
        burst_pairs <= bl_pairs;
    end
  end

  // per-bank row state; ACTIVE to another bank is taken at any time
  genvar b;
  generate
    for (b = 0; b < NB; b++)
    begin : g_bank
      wire hit     = (ba == lpddr_rd_pkg::BA_W'(b));
      wire act_b   = is_act & hit;
      wire pre_b   = is_pre & (sel_all | hit);
      // auto precharge is armed by the final pair and fires once active time is met
      wire arm_b   = iss_last & iss_ap & (iss_bank == lpddr_rd_pkg::BA_W'(b));
      assign ras_met[b] = (ras_cnt[b] == RAS_MET);
      assign ap_fire[b] = ap_pend[b] & ras_met[b];

      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          bank_open[b] <= 1'b0;
          bank_row[b]  <= '0;
          ras_cnt[b]   <= '0;
          ap_pend[b]   <= 1'b0;
        end
        else
        begin
          if (act_b)
          begin
            bank_open[b] <= 1'b1;
            bank_row[b]  <= addr;
            ras_cnt[b]   <= '0;
          end
          else
          begin
            if (pre_b | ap_fire[b])
              bank_open[b] <= 1'b0;
            if (!ras_met[b])
              ras_cnt[b] <= RCW'(ras_cnt[b] + 1'b1);
          end
          // arming wins over a firing in the same cycle
          ap_pend[b] <= arm_b | (ap_pend[b] & ~ap_fire[b]);
        end
      end
    end
  endgenerate

  // latency pipe: storage output is stage 0, one more stage for latency 3
  wire            tap_v   = cl3 ? s1_v : s0_v;
  wire [DW-1:0]   tap_d   = cl3 ? s1_d : mbus.rd_data;
  wire            tap_pre = cl3 ? (s0_v & ~s1_v) : (issue_v & ~s0_v);

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s0_v <= 1'b0;
      s1_v <= 1'b0;
      s1_d <= '0;
    end
    else
    begin
      s0_v <= issue_v;
      s1_v <= s0_v;
      s1_d <= mbus.rd_data;
    end
  end

  // output stage: a pair per cycle, strobe high then low with each pair
  // the low half of the last pair doubles as the postamble
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dq_rise  <= '0;
      dq_fall  <= '0;
      dq_oe_n  <= 1'b1;
      dqs_o    <= 1'b0;
      dqs_oe_n <= 1'b1;
      out_pre  <= 1'b0;
    end
    else
    begin
      dq_rise  <= tap_d[DW-1:lpddr_rd_pkg::DQ_W];
      dq_fall  <= tap_d[lpddr_rd_pkg::DQ_W-1:0];
      dq_oe_n  <= ~tap_v;
      dqs_o    <= tap_v;
      dqs_oe_n <= ~(tap_v | tap_pre);
      out_pre  <= tap_pre;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  AST_ACT_OPENS: assert property (is_act |=> bank_open[$past(ba)])
    else $error("active did not open the bank");
  AST_CL2_FIRST: assert property (rd_ok && !cl3 |-> ##2 !dq_oe_n)
    else $error("latency 2 data missing");
  AST_CL3_FIRST: assert property (rd_ok && cl3 |-> ##3 !dq_oe_n)
    else $error("latency 3 data missing");
  AST_PREAMBLE: assert property ($fell(dqs_oe_n) |-> !dqs_o && dq_oe_n && out_pre)
    else $error("strobe did not start low");
  AST_STROBE_WITH_DATA: assert property (!dq_oe_n |-> !dqs_oe_n && dqs_o)
    else $error("strobe not driven with data");
  AST_RELEASE: assert property ($rose(dq_oe_n) |-> dqs_oe_n || out_pre)
    else $error("strobe kept after burst");
  AST_BST_CL2: assert property (is_bst && !cl3 |-> ##2 dq_oe_n)
    else $error("terminate did not cut the burst");
  AST_BST_OPEN: assert property (is_bst && bank_open[burst_bank] |=> bank_open[$past(burst_bank)])
    else $error("terminate closed the page");
  AST_PRE_CUT: assert property (pre_cut |=> state == lpddr_rd_pkg::ST_IDLE && !s0_v)
    else $error("precharge did not stop the burst");
  AST_RD_ANY_CYCLE: assert property (rd_ok && bl_pairs != PAIRS_ONE |=> bursting)
    else $error("read not taken");
  AST_AP_BL2: assert property (iss_last && iss_ap && ras_met[iss_bank] && !is_act
                               |=> ##1 !bank_open[$past(iss_bank, 2)])
    else $error("auto precharge late");
endmodule : lpddr_read_path
`default_nettype wire

// ===== verification/sdram_cmd_model.sv
// controller-side command source for the read path bench
// assumes the bench supplies the clock and a count of rising edges
`timescale 1ns/100ps
`default_nettype none
module sdram_cmd_model #(
  parameter int RCD_CYC = 1,  // 15 ns over 25 ns, rounded up
  parameter int RC_CYC  = 3,  // 55 ns over 25 ns, rounded up
  parameter int RRD_CYC = 1,  // 10 ns over 25 ns, rounded up
  parameter int RP_CYC  = 1   // 15 ns over 25 ns, rounded up
) (
  input  wire logic        clk,    // command clock
  input  wire logic [31:0] cyc,    // rising edges so far
  output logic             cs_n,   // chip select
  output logic             ras_n,  // row strobe
  output logic             cas_n,  // column strobe
  output logic             we_n,   // write enable
  output logic [1:0]       ba,     // bank
  output logic [12:0]      addr    // address
);
  // per-bank timers and one across banks; no write is ever sent, so no burst must end first
  int last_act[4];
  int last_pre[4];
  int last_any;

  // deselected pins wander so stale values cannot be leaned on
  task automatic idle();
    cs_n = 1'b1;
    {ras_n, cas_n, we_n} = ~{ras_n, cas_n, we_n};
    ba = ~ba;
    addr = ~addr;
  endtask : idle

  // quiet pins at time zero
  initial
  begin
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    ba = 2'h0;
    addr = 13'h0;
    last_act = '{default: -100};
    last_pre = '{default: -100};
    last_any = -100;
  end

  task automatic nop();
    @(negedge clk);
    idle();
  endtask : nop

  // waits until spacing allows the command, then drives it for one cycle
  task automatic issue(input logic [2:0] code, input logic [1:0] b, input logic [12:0] a,
                       output int c);
    bit act;
    act = (code == lpddr_rd_pkg::CODE_ACT);
    @(negedge clk);
    c = int'(cyc);
    while ((act && (c < last_act[b] + RC_CYC || c < last_any + RRD_CYC))
           || (code == lpddr_rd_pkg::CODE_RD && c < last_act[b] + RCD_CYC)
           || c < last_pre[b] + RP_CYC)
    begin
      idle();
      @(negedge clk);
      c = int'(cyc);
    end
    cs_n = 1'b0;
    {ras_n, cas_n, we_n} = code;
    ba = b;
    addr = a;
    if (act)
    begin
      last_act[b] = c;
      last_any = c;
    end
    if (code == lpddr_rd_pkg::CODE_PRE)
      last_pre[b] = c;
  endtask : issue
endmodule : sdram_cmd_model
`default_nettype wire

// ===== verification/lpddr_read_path_tb.sv
// self-checking bench for the read path: activation, bursts, truncation, precharge
// assumes default storage geometry: word address {bank, row[1:0], column pair[3:0]}
`timescale 1ns/100ps
`default_nettype none
module lpddr_read_path_tb;
  localparam logic [2:0] ACT = lpddr_rd_pkg::CODE_ACT;
  localparam logic [2:0] RD  = lpddr_rd_pkg::CODE_RD;
  logic        clk, nrst, cl3, load_en, cs_n, ras_n, cas_n, we_n;
  logic [1:0]  bl_sel, ba;
  logic [12:0] addr;
  logic [7:0]  load_addr;
  logic [31:0] load_data, cyc;
  logic [15:0] dq_rise, dq_fall;
  logic        dq_oe_n, dqs_o, dqs_oe_n;
  logic [3:0]  bank_open;
  logic [15:0] lr[4096], lf[4096];
  logic        lo[4096], ls[4096], lso[4096];
  logic [3:0]  lbo[4096];
  int          bad_count, comparisons;

  lpddr_read_path i_lpddr_read_path (.clk(clk), .nrst(nrst), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr), .cl3(cl3), .bl_sel(bl_sel),
    .load_en(load_en), .load_addr(load_addr), .load_data(load_data), .dq_rise(dq_rise),
    .dq_fall(dq_fall), .dq_oe_n(dq_oe_n), .dqs_o(dqs_o), .dqs_oe_n(dqs_oe_n),
    .bank_open(bank_open));
  sdram_cmd_model i_sdram_cmd_model (.clk(clk), .cyc(cyc), .cs_n(cs_n), .ras_n(ras_n),
    .cas_n(cas_n), .we_n(we_n), .ba(ba), .addr(addr));

  // 25 ns clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // cycle count and a mid-cycle log of every output, so each cycle is judged later
  always @(posedge clk) cyc <= cyc + 32'h1;
  always @(negedge clk)
  begin
    lr[cyc[11:0]] = dq_rise;
    lf[cyc[11:0]] = dq_fall;
    lo[cyc[11:0]] = dq_oe_n;
    ls[cyc[11:0]] = dqs_o;
    lso[cyc[11:0]] = dqs_oe_n;
    lbo[cyc[11:0]] = bank_open;
  end

  task automatic cmp_word(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp_word

  task automatic cmp_bit(input logic got, input logic exp);
    cmp_word({15'h0, got}, {15'h0, exp});
  endtask : cmp_bit

  // one driven pair of word w in cycle c
  task automatic chk_pair(input int c, input logic [7:0] w);
    cmp_bit(lo[c], 1'b0);
    cmp_bit(lso[c], 1'b0);
    cmp_bit(ls[c], 1'b1);
    cmp_word(lr[c], {8'hc3, w});
    cmp_word(lf[c], {8'h3c, ~w});
  endtask : chk_pair

  task automatic cmd(input logic [2:0] code, input logic [1:0] b, input logic [12:0] a,
                     output int c);
    i_sdram_cmd_model.issue(code, b, a, c);
  endtask : cmd

  task automatic t_reset();
    repeat (5) @(negedge clk);
    cmp_bit(dq_oe_n, 1'b1);
    cmp_bit(dqs_oe_n, 1'b1);
    cmp_word({12'h0, bank_open}, 16'h0);
    nrst = 1'b1;
    for (int i = 0; i < 256; i++)
    begin
      @(negedge clk);
      load_en = 1'b1;
      load_addr = 8'(i);
      load_data = {8'hc3, 8'(i), 8'h3c, ~8'(i)};
    end
    @(negedge clk);
    load_en = 1'b0;
  endtask : t_reset

  task automatic t_act();
    int c0;
    int c1;
    cmd(ACT, 2'h0, 13'h0001, c0);
    cmd(ACT, 2'h1, 13'h0002, c1);
    i_sdram_cmd_model.nop();
    repeat (3) @(negedge clk);
    cmp_bit(lbo[c0][0], 1'b0);
    cmp_bit(lbo[c0 + 1][0], 1'b1);
    cmp_bit(lbo[c1 + 1][1], 1'b1);
  endtask : t_act

  // column pair 5 so that longer bursts wrap inside their block
  task automatic t_read(input logic cl, input logic [1:0] sel, input int pairs);
    int c;
    int p;
    logic [3:0] m;
    m = 4'(pairs - 1);
    cl3 = cl;
    bl_sel = sel;
    cmd(RD, 2'h0, 13'h000a, c);
    i_sdram_cmd_model.nop();
    repeat (12) @(negedge clk);
    p = c + 1 + int'(cl);
    cmp_bit(lso[p], 1'b0);
    cmp_bit(ls[p], 1'b0);
    cmp_bit(lo[p], 1'b1);
    for (int k = 0; k < pairs; k++)
      chk_pair(p + 1 + k, {4'h1, (4'h5 & ~m) | (4'(5 + k) & m)});
    cmp_bit(lo[p + 1 + pairs], 1'b1);
    cmp_bit(lso[p + 1 + pairs], 1'b1);
  endtask : t_read

  // second read cut to one pair by a third, all in one unbroken stream
  task automatic t_concat();
    int c0;
    int c1;
    int c2;
    cl3 = 1'b0;
    bl_sel = 2'h2;
    cmd(RD, 2'h0, 13'h0000, c0);
    i_sdram_cmd_model.nop();
    cmd(RD, 2'h1, 13'h0010, c1);
    cmd(RD, 2'h0, 13'h0004, c2);
    i_sdram_cmd_model.nop();
    repeat (8) @(negedge clk);
    chk_pair(c0 + 2, 8'h10);
    chk_pair(c0 + 3, 8'h11);
    chk_pair(c1 + 2, 8'h68);
    chk_pair(c2 + 2, 8'h12);
    chk_pair(c2 + 3, 8'h13);
    cmp_bit(lo[c2 + 4], 1'b1);
  endtask : t_concat

  // terminate or precharge one cycle after an eight or four long read
  task automatic t_cut(input logic [2:0] code, input logic [1:0] b, input logic [1:0] sel,
                       input logic [7:0] w, input logic still_open);
    int c;
    int d;
    bl_sel = sel;
    cmd(RD, b, 13'h0008, c);
    cmd(code, b, 13'h0000, d);
    i_sdram_cmd_model.nop();
    repeat (8) @(negedge clk);
    chk_pair(c + 2, w);
    cmp_bit(lo[c + 3], 1'b1);
    cmp_bit(lbo[c + 4][b], still_open);
  endtask : t_cut

  // reopened bank closes on its own a burst plus one cycle after the read; with four pairs
  // the active time is already met when the last pair goes out
  task automatic t_autopre(input logic [1:0] sel, input int pairs, input logic [1:0] row);
    int a;
    int c;
    bl_sel = sel;
    cmd(ACT, 2'h0, {11'h0, row}, a);
    cmd(RD, 2'h0, 13'h0400, c);
    i_sdram_cmd_model.nop();
    repeat (10) @(negedge clk);
    for (int k = 0; k < pairs; k++)
      chk_pair(c + 2 + k, {2'h0, row, 4'(k)});
    cmp_bit(lbo[c + pairs][0], 1'b1);
    cmp_bit(lbo[c + pairs + 1][0], 1'b0);
  endtask : t_autopre

  task automatic t_closed();
    int c;
    cmd(RD, 2'h3, 13'h0000, c);
    i_sdram_cmd_model.nop();
    repeat (6) @(negedge clk);
    cmp_bit(lso[c + 1], 1'b1);
    cmp_bit(lo[c + 2], 1'b1);
  endtask : t_closed

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : end_of_test

  // main sequence
  initial
  begin
    {nrst, cl3, load_en} = 3'h0;
    bl_sel = 2'h2;
    load_addr = 8'h0;
    load_data = 32'h0;
    cyc = 32'h0;
    bad_count = 0;
    comparisons = 0;
    t_reset();
    t_act();
    for (int i = 0; i < 2; i++)
    begin
      t_read(i[0], 2'h0, 1);
      t_read(i[0], 2'h2, 2);
      t_read(i[0], 2'h3, 4);
    end
    t_concat();
    t_cut(lpddr_rd_pkg::CODE_BST, 2'h1, 2'h3, 8'h64, 1'b1);
    t_cut(lpddr_rd_pkg::CODE_PRE, 2'h0, 2'h2, 8'h14, 1'b0);
    t_autopre(2'h2, 2, 2'h2);
    t_autopre(2'h3, 4, 2'h3);
    t_closed();
    end_of_test();
  end

  // about 420 cycles are needed; a hang is cut off well beyond that
  initial
  begin
    repeat (5000) @(posedge clk);
    bad_count++;
    end_of_test();
  end
endmodule : lpddr_read_path_tb
`default_nettype wire
